// *** hw/gauge_pkg.sv ***
package gauge_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] FULL_CAP_ADDR = 8'h10;
    localparam logic [7:0] GATE_ADDR = 8'h13;
    localparam logic [7:0] TERM_ADDR = 8'h1E;
    localparam logic [7:0] LEARN_ADDR = 8'h28;
    localparam logic [7:0] EMPTY_ADDR = 8'h3A;
    localparam logic [7:0] STATUS_ADDR = 8'h3E;
    localparam logic [7:0] TABLE_BASE = 8'h80;
    localparam logic [7:0] TABLE_LAST = 8'hAF;
    localparam int TABLE_WORDS = 48;
    localparam int MISC_COUNT = 9;
    // residual_q_0..3, design_capacity, nominal_full_capacity,
    // average_empty_current, cell_model_resistance, thermal_coefficient
    localparam logic [7:0] MISC_ADDR [MISC_COUNT] = '{
        8'h12, 8'h22, 8'h32, 8'h42, 8'h18, 8'h23, 8'h36, 8'h38, 8'h39
    };

    // ==========================================================
    // reset values
    localparam logic [15:0] FULL_CAP_RST = 16'h0000;
    localparam logic [15:0] GATE_RST = 16'h4600;
    localparam logic [15:0] TERM_RST = 16'h03C0;
    localparam logic [15:0] EMPTY_RST = 16'h9C5C;
    localparam logic [15:0] MISC_RST = 16'h0000;
    localparam logic FILT_EMPTY_RST = 1'b0;

    // ==========================================================
    // field positions and scaling
    localparam int TRIP_LSB = 7;
    localparam int TRIP_W = 9;
    localparam int REARM_LSB = 0;
    localparam int REARM_W = 7;
    localparam int FILT_EMPTY_BIT = 2;
    localparam logic [15:0] TRIP_STEP_MV = 16'h000A;
    localparam logic [15:0] REARM_STEP_MV = 16'h0028;
    localparam int LO_SHIFT = 3;
    localparam int HI_SHIFT = 2;

    // bus address, value arbitrary
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [15:0] soc_vf;
        logic signed [15:0] current;
        logic signed [15:0] avg_current;
        logic [15:0] vcell_mv;
        logic [15:0] avg_vcell_mv;
        logic [15:0] rem_cap;
    } meas_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [15:0] data;
    } reg_wr_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_RX,
        S_RX_ACK,
        S_TX,
        S_TX_ACK
    } twi_state_t;

endpackage : gauge_pkg

// *** hw/two_wire_slave.sv ***
`timescale 1ns/1ps
module two_wire_slave import gauge_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
    input wire logic mclk_i,         // system clock
    input wire logic reset_n_i,      // sync reset, active low
    input wire logic scl_i,          // serial clock pin
    input wire logic sda_i,          // serial data pin in
    output logic sda_drive_low_o,    // pull data line low
    output reg_wr_t wr_o,            // register write pulse
    output logic [7:0] rd_addr_o,    // register read pointer
    input wire logic [15:0] rd_data_i // read word for pointer
);

    logic scl_meta, scl_s, scl_d;
    logic sda_meta, sda_s, sda_d;
    twi_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] lo_hold;
    logic [7:0] ptr;
    logic rw, have_ptr, hi_byte;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] tx_byte;
    logic byte_done;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge mclk_i) begin
        scl_meta <= scl_i;
        scl_s <= scl_meta;
        scl_d <= scl_s;
        sda_meta <= sda_i;
        sda_s <= sda_meta;
        sda_d <= sda_s;
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    assign tx_byte = hi_byte ? rd_data_i[15:8] : rd_data_i[7:0];
    assign byte_done = scl_fall && (bit_cnt == 4'h8);
    assign rd_addr_o = ptr;

    // ==========================================================
    // protocol engine, low byte first, pointer auto-increments
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            lo_hold <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            hi_byte <= 1'b0;
            sda_drive_low_o <= 1'b0;
            wr_o <= '0;
        end else begin
            wr_o.valid <= 1'b0;
            if (start_cond) begin
                state <= S_ADDR;
                bit_cnt <= 4'h0;
                have_ptr <= 1'b0;
                hi_byte <= 1'b0;
                sda_drive_low_o <= 1'b0;
            end else if (stop_cond) begin
                state <= S_IDLE;
                sda_drive_low_o <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_RX: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt <= 4'h0;
                            if (state == S_ADDR) begin
                                if (shreg[7:1] == DEV_ADDR) begin
                                    rw <= shreg[0];
                                    sda_drive_low_o <= 1'b1;
                                    state <= S_ADDR_ACK;
                                end else begin
                                    state <= S_IDLE;
                                end
                            end else begin
                                sda_drive_low_o <= 1'b1;
                                state <= S_RX_ACK;
                                if (!have_ptr) begin
                                    ptr <= shreg;
                                    have_ptr <= 1'b1;
                                end else if (!hi_byte) begin
                                    lo_hold <= shreg;
                                    hi_byte <= 1'b1;
                                end else begin
                                    wr_o.valid <= 1'b1;
                                    wr_o.addr <= ptr;
                                    wr_o.data <= {shreg, lo_hold};
                                    ptr <= ptr + 8'h01;
                                    hi_byte <= 1'b0;
                                end
                            end
                        end
                    end
                    S_ADDR_ACK, S_RX_ACK: begin
                        if (scl_fall) begin
                            if (state == S_ADDR_ACK && rw) begin
                                shreg <= tx_byte;
                                sda_drive_low_o <= ~tx_byte[7];
                                state <= S_TX;
                            end else begin
                                sda_drive_low_o <= 1'b0;
                                state <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt <= 4'h0;
                            sda_drive_low_o <= 1'b0;
                            state <= S_TX_ACK;
                        end else if (scl_fall) begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_drive_low_o <= ~shreg[6];
                        end
                    end
                    S_TX_ACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state <= S_IDLE;
                            end
                            if (hi_byte) begin
                                ptr <= ptr + 8'h01;
                            end
                            hi_byte <= ~hi_byte;
                        end else if (scl_fall) begin
                            shreg <= tx_byte;
                            sda_drive_low_o <= ~tx_byte[7];
                            state <= S_TX;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : two_wire_slave

// *** hw/charge_end_and_empty_detect.sv ***
`timescale 1ns/1ps
module charge_end_and_empty_detect import gauge_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
    input wire logic mclk_i,         // system clock 125 MHz
    input wire logic reset_n_i,      // sync reset, active low
    input wire logic scl_i,          // serial clock pin
    input wire logic sda_i,          // serial data pin in
    output logic sda_o,              // serial data out, always low
    output logic sda_oe_n_o,         // low while pulling data low
    input meas_t meas_i,             // measurement update
    output logic eoc_o,              // end of charge pulse
    output logic empty_o,            // empty flag
    output logic [15:0] full_cap_o   // learned full capacity
);

    reg_wr_t wr;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic drive_low;

    logic [15:0] full_cap;
    logic [15:0] gate;
    logic [15:0] term_thr;
    logic [15:0] empty_cfg;
    logic filt_empty;
    logic [15:0] misc [MISC_COUNT];
    logic [15:0] cell_table [TABLE_WORDS];
    logic lower_pend;
    logic [15:0] pend_cap;
    logic eoc_last;
    logic empty;

    // ==========================================================
    // serial register port
    two_wire_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_twi (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_drive_low_o(drive_low),
        .wr_o(wr),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drive_low;

    // ==========================================================
    // write decode
    logic wr_full_cap, wr_gate, wr_term, wr_empty, wr_learn, wr_table;
    logic [5:0] wr_tbl_idx;
    assign wr_full_cap = wr.valid && (wr.addr == FULL_CAP_ADDR);
    assign wr_gate = wr.valid && (wr.addr == GATE_ADDR);
    assign wr_term = wr.valid && (wr.addr == TERM_ADDR);
    assign wr_empty = wr.valid && (wr.addr == EMPTY_ADDR);
    assign wr_learn = wr.valid && (wr.addr == LEARN_ADDR);
    assign wr_table = wr.valid && (wr.addr >= TABLE_BASE) && (wr.addr <= TABLE_LAST);
    assign wr_tbl_idx = 6'(wr.addr - TABLE_BASE);

    // ==========================================================
    // read select, unmapped reads zero
    logic rd_table;
    logic [5:0] rd_tbl_idx;
    logic [15:0] misc_rd;
    logic [15:0] learn_word;
    logic [15:0] status_word;
    assign rd_table = (rd_addr >= TABLE_BASE) && (rd_addr <= TABLE_LAST);
    assign rd_tbl_idx = 6'(rd_addr - TABLE_BASE);
    assign learn_word = 16'(filt_empty) << FILT_EMPTY_BIT;
    assign status_word = {13'h0000, eoc_last, lower_pend, empty};

    always_comb begin
        misc_rd = 16'h0000;
        for (int i = 0; i < MISC_COUNT; i++) begin
            if (rd_addr == MISC_ADDR[i]) begin
                misc_rd = misc_rd | misc[i];
            end
        end
    end

    assign rd_data = (rd_addr == FULL_CAP_ADDR) ? full_cap :
                     (rd_addr == GATE_ADDR) ? gate :
                     (rd_addr == TERM_ADDR) ? term_thr :
                     (rd_addr == EMPTY_ADDR) ? empty_cfg :
                     (rd_addr == LEARN_ADDR) ? learn_word :
                     (rd_addr == STATUS_ADDR) ? status_word :
                     rd_table ? cell_table[rd_tbl_idx] : misc_rd;

    // ==========================================================
    // configuration registers
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            gate <= GATE_RST;
            term_thr <= TERM_RST;
            empty_cfg <= EMPTY_RST;
            filt_empty <= FILT_EMPTY_RST;
        end else begin
            if (wr_gate) begin
                gate <= wr.data;
            end
            if (wr_term) begin
                term_thr <= wr.data;
            end
            if (wr_empty) begin
                empty_cfg <= wr.data;
            end
            if (wr_learn) begin
                filt_empty <= wr.data[FILT_EMPTY_BIT];
            end
        end
    end

    for (genvar g = 0; g < MISC_COUNT; g++) begin : g_misc
        always_ff @(posedge mclk_i) begin
            if (!reset_n_i) begin
                misc[g] <= MISC_RST;
            end else if (wr.valid && (wr.addr == MISC_ADDR[g])) begin
                misc[g] <= wr.data;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wr_table) begin
            cell_table[wr_tbl_idx] <= wr.data;
        end
    end

    // ==========================================================
    // end of charge qualification
    logic signed [17:0] thr_ext, lo_band, hi_band, cur_ext, avg_ext;
    logic soc_ok, cur_ok, avg_ok, eoc_qual;
    assign thr_ext = 18'(signed'(term_thr));
    assign lo_band = thr_ext >>> LO_SHIFT;
    assign hi_band = thr_ext + (thr_ext >>> HI_SHIFT);
    assign cur_ext = 18'(meas_i.current);
    assign avg_ext = 18'(meas_i.avg_current);
    assign soc_ok = meas_i.soc_vf > gate;
    assign cur_ok = (cur_ext > lo_band) && (cur_ext < hi_band);
    assign avg_ok = (avg_ext > lo_band) && (avg_ext < hi_band);
    assign eoc_qual = soc_ok && cur_ok && avg_ok;

    // ==========================================================
    // full capacity learning
    logic cap_low;
    assign cap_low = meas_i.rem_cap >= full_cap;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            full_cap <= FULL_CAP_RST;
            lower_pend <= 1'b0;
            pend_cap <= 16'h0000;
        end else if (meas_i.valid && eoc_qual) begin
            if (cap_low) begin
                full_cap <= meas_i.rem_cap;
                lower_pend <= 1'b0;
            end else begin
                lower_pend <= 1'b1;
                pend_cap <= meas_i.rem_cap;
            end
        end else if (meas_i.valid && lower_pend) begin
            full_cap <= pend_cap;
            lower_pend <= 1'b0;
        end else if (wr_full_cap) begin
            full_cap <= wr.data;
            lower_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            eoc_o <= 1'b0;
            eoc_last <= 1'b0;
        end else begin
            eoc_o <= meas_i.valid && eoc_qual;
            if (meas_i.valid) begin
                eoc_last <= eoc_qual;
            end
        end
    end

    assign full_cap_o = full_cap;

    // ==========================================================
    // empty detection with rearm hysteresis
    logic [15:0] v_sel, trip_mv, rearm_mv;
    logic trip_hit, rearm_hit;
    assign v_sel = filt_empty ? meas_i.avg_vcell_mv : meas_i.vcell_mv;
    assign trip_mv = 16'(empty_cfg[TRIP_LSB +: TRIP_W]) * TRIP_STEP_MV;
    assign rearm_mv = 16'(empty_cfg[REARM_LSB +: REARM_W]) * REARM_STEP_MV;
    assign trip_hit = v_sel <= trip_mv;
    assign rearm_hit = v_sel > rearm_mv;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            empty <= 1'b0;
        end else if (meas_i.valid) begin
            if (!empty && trip_hit) begin
                empty <= 1'b1;
            end else if (empty && rearm_hit) begin
                empty <= 1'b0;
            end
        end
    end

    assign empty_o = empty;

    // ==========================================================
    // checks
    eoc_gate_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        eoc_o |-> $past(soc_ok))
        else $error("end of charge without soc above gate");

    eoc_cur_band_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && (cur_ext <= lo_band || cur_ext >= hi_band) |=> !eoc_o)
        else $error("end of charge with current out of band");

    eoc_avg_band_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && (avg_ext <= lo_band || avg_ext >= hi_band) |=> !eoc_o)
        else $error("end of charge with averaged current out of band");

    eoc_both_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && soc_ok && cur_ok && avg_ok |=>
        eoc_o ##1 (eoc_o == $past(meas_i.valid && eoc_qual)))
        else $error("qualified end of charge not flagged once");

    cap_raise_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && eoc_qual && cap_low |=> full_cap == $past(meas_i.rem_cap))
        else $error("low capacity not raised to remaining");

    cap_lower_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        lower_pend && meas_i.valid && !eoc_qual |=>
        full_cap == $past(pend_cap) && !lower_pend)
        else $error("high capacity not lowered after last event");

    cap_cover_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        eoc_o && !lower_pend |-> full_cap >= $past(meas_i.rem_cap))
        else $error("capacity left below remaining capacity");

    reset_values_a: assert property (@(posedge mclk_i)
        $rose(reset_n_i) |-> term_thr == TERM_RST && gate == GATE_RST &&
        empty_cfg == EMPTY_RST && !empty_o && !eoc_o)
        else $error("power-up defaults wrong");

    empty_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && !empty && trip_hit |=> empty_o)
        else $error("empty not set at trip level");

    empty_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        empty && !(meas_i.valid && rearm_hit) |=> empty_o)
        else $error("empty dropped before rearm");

    empty_rearm_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && empty && rearm_hit |=> !empty_o)
        else $error("empty not cleared above rearm level");

    eoc_upd_only_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !meas_i.valid |=> !eoc_o)
        else $error("end of charge without measurement update");

    empty_upd_only_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !meas_i.valid |=> $stable(empty_o))
        else $error("empty flag moved without measurement update");

    cap_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !meas_i.valid && !wr_full_cap |=> $stable(full_cap_o))
        else $error("full capacity moved without update or write");

    cap_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        wr_full_cap && !meas_i.valid |=> full_cap_o == $past(wr.data) && !lower_pend)
        else $error("host write of full capacity lost");

    filt_avg_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && filt_empty && !empty && meas_i.avg_vcell_mv <= trip_mv |=> empty_o)
        else $error("empty not taken from averaged voltage");

    filt_inst_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        meas_i.valid && !filt_empty && !empty && meas_i.vcell_mv <= trip_mv |=> empty_o)
        else $error("empty not taken from instantaneous voltage");

endmodule : charge_end_and_empty_detect

// *** verification/twi_host.sv ***
`timescale 1ns/1ps
module twi_host import gauge_pkg::*; (
    input wire logic mclk_i, // bench clock
    input wire logic sda_i,  // resolved data line, pulled up
    output logic scl_o,      // serial clock
    output logic pull_o      // pull data line low
);
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tk
    // =====
    // bit level: data moves mid low, sampled mid high
    task automatic bx(input logic b, output logic r);
        scl_o = 1'b0;
        tk(6);
        pull_o = !b;
        tk(6);
        scl_o = 1'b1;
        tk(6);
        r = sda_i;
        tk(6);
    endtask : bx
    // start or repeated start when s, stop otherwise
    task automatic cond(input logic s);
        scl_o = 1'b0;
        tk(6);
        pull_o = !s;
        tk(6);
        scl_o = 1'b1;
        tk(12);
        pull_o = s;
        tk(12);
    endtask : cond
    task automatic by(input logic [7:0] d, input logic ab, output logic [7:0] r,
                      inout int ak);
        logic a;
        for (int i = 7; i >= 0; i--)
            bx(d[i], r[i]);
        bx(ab, a);
        if (!a)
            ak++;
    endtask : by
    // =====
    // word transfers, low byte first
    task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] d,
                      output int ak);
        logic [7:0] r;
        ak = 0;
        cond(1'b1);
        by({dev, 1'b0}, 1'b1, r, ak);
        by(p, 1'b1, r, ak);
        by(d[7:0], 1'b1, r, ak);
        by(d[15:8], 1'b1, r, ak);
        cond(1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        int ak;
        ak = 0;
        cond(1'b1);
        by({DEV_ADDR_DFLT, 1'b0}, 1'b1, d[7:0], ak);
        by(p, 1'b1, d[7:0], ak);
        cond(1'b1);
        by({DEV_ADDR_DFLT, 1'b1}, 1'b1, d[7:0], ak);
        by(8'hFF, 1'b0, d[7:0], ak);
        by(8'hFF, 1'b1, d[15:8], ak);
        cond(1'b0);
    endtask : rd
endmodule : twi_host

// *** verification/charge_end_and_empty_detect_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module charge_end_and_empty_detect_tb import gauge_pkg::*;;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic scl, pull, sda_oe_n, sd_o, eoc, empty;
    logic [15:0] full_cap, x;
    meas_t meas = '0;
    wire logic sda = !(pull || sda_oe_n === 1'b0);
    int n_mismatch = 0, cmp_count = 0, seed = 59609, ak;
    int thr = 960, gate = 'h4600, trip = 3120, rearm = 3680, fc = 0, pend = 0, pv = 0, emp = 0;
    bit filt = 0;
    logic [7:0] ra [5] = '{8'h13, 8'h1E, 8'h3A, 8'h28, 8'h10};
    logic [15:0] rv [5] = '{16'h4600, 16'h03C0, {9'd312, 7'd92}, 16'h0000, 16'h0000};

    always #4 mclk_i = !mclk_i;

    twi_host i_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    charge_end_and_empty_detect i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sd_o), .sda_oe_n_o(sda_oe_n), .meas_i(meas), .eoc_o(eoc),
        .empty_o(empty), .full_cap_o(full_cap));

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic tk();
        @(posedge mclk_i);
        #1;
    endtask : tk
    // boundary values or a spread around a band
    function automatic int pk(input int lo, input int hi);
        int r;
        r = $random(seed);
        case (r & 7)
            0: return lo;
            1: return lo + 1;
            2: return hi - 1;
            3: return hi;
            default: return lo - 20 + (r >> 4) % (hi - lo + 40);
        endcase
    endfunction : pk
    task automatic wrc(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] d,
                       input bit eak, input logic [15:0] erd);
        i_host.wr(dev, p, d, ak);
        `CHK("ack", eak, ak != 0)
        i_host.rd(p, x);
        `CHK("reg", erd, x)
        `CHK("sda_o", 1'b0, sd_o)
    endtask : wrc
    // =====
    // one measurement update against the reference model
    task automatic upd(input int soc, cur, avg, vc, va, rem);
        int lo, hi, v;
        bit q;
        lo = thr >>> 3;
        hi = thr + (thr >>> 2);
        q = soc > gate && cur > lo && cur < hi && avg > lo && avg < hi;
        v = filt ? va : vc;
        tk();
        meas = '{1'b1, 16'(soc), 16'(cur), 16'(avg), 16'(vc), 16'(va), 16'(rem)};
        tk();
        meas.valid = 1'b0;
        if (q && rem >= fc) begin
            fc = rem;
            pend = 0;
        end else if (q) begin
            pend = 1;
            pv = rem;
        end else if (pend) begin
            fc = pv;
            pend = 0;
        end
        if (!emp && v <= trip)
            emp = 1;
        else if (emp && v > rearm)
            emp = 0;
        `CHK("eoc", q, eoc)
        `CHK("full_cap", 16'(fc), full_cap)
        `CHK("empty", emp[0], empty)
    endtask : upd

    initial begin
        repeat (90000) @(posedge mclk_i);
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            i_host.rd(ra[i], x);
            `CHK("reset", rv[i], x)
        end
        wrc(DEV_ADDR_DFLT ^ 7'h01, 8'h1E, 16'h0BAD, 1'b0, 16'h03C0);
        wrc(DEV_ADDR_DFLT, 8'h05, 16'hFFFF, 1'b1, 16'h0000);
        wrc(DEV_ADDR_DFLT, 8'h36, 16'h1234, 1'b1, 16'h1234);
        wrc(DEV_ADDR_DFLT, 8'hAF, 16'hBEEF, 1'b1, 16'hBEEF);
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                wrc(DEV_ADDR_DFLT, 8'h1E, 16'h0100, 1'b1, 16'h0100);
                wrc(DEV_ADDR_DFLT, 8'h13, 16'h5000, 1'b1, 16'h5000);
                wrc(DEV_ADDR_DFLT, 8'h3A, {9'd300, 7'd80}, 1'b1, {9'd300, 7'd80});
                wrc(DEV_ADDR_DFLT, 8'h28, 16'h0004, 1'b1, 16'h0004);
                thr = 'h100;
                gate = 'h5000;
                trip = 300 * 10;
                rearm = 80 * 40;
                filt = 1;
            end
            for (int i = 0; i < 150; i++)
                upd(pk(gate, gate), pk(thr >>> 3, thr + (thr >>> 2)),
                    pk(thr >>> 3, thr + (thr >>> 2)), pk(trip, rearm), pk(trip, rearm),
                    fc + ($random(seed) & 15));
        end
        i_host.rd(8'h10, x);
        `CHK("full_cap_reg", 16'(fc), x)
        wrc(DEV_ADDR_DFLT, 8'h10, 16'h0800, 1'b1, 16'h0800);
        fc = 'h800;
        pend = 0;
        upd(gate + 1, 40, 40, 4000, 4000, 'h700);
        i_host.rd(8'h3E, x);
        `CHK("status", {13'h0000, 1'b1, 1'b1, emp[0]}, x)
        upd(gate, 40, 40, 2000, 2000, 'h700);
        upd(gate + 1, 40, 40, 4000, 4000, 'h900);
        end_sim();
    end
endmodule : charge_end_and_empty_detect_tb
